// ==== hdl/flash_params.svh ====
// Constants for the flash program and erase controller.
// Assumes inclusion by bare name from the hdl/ folder.
`ifndef FLASH_PARAMS_SVH
`define FLASH_PARAMS_SVH
// Opcodes
`define OP_PROG 8'h02
`define OP_PROG_Q1 8'h32
`define OP_PROG_Q2 8'h38
`define OP_SER_A 8'hD7
`define OP_SER_B 8'h20
`define OP_BER32 8'h52
`define OP_BER64 8'hD8
`define OP_CER_A 8'hC7
`define OP_CER_B 8'h60
`define OP_WRITE_ENABLE_CMD 8'h06
`define OP_WRITE_DISABLE_CMD 8'h04
`define OP_STATUS_READ_CMD 8'h05
// Array geometry
`define ARRAY_AW 21
`define ARRAY_ALL 21'h1F_FFFF
`define SECT_MASK 21'h0_0FFF
`define BLK32_MASK 21'h0_7FFF
`define BLK64_MASK 21'h0_FFFF
`define PAGE_LAST 8'hFF
`define BLK64_COUNT 6'h20
// Frame layout: opcode plus three address bytes
`define HDR_BYTES 10'h004
`define NBYTES_SAT 10'h3FF
// Status byte fields
`define ST_WIP 0
`define ST_WEL 1
`define ST_QE 6
`endif

// ==== hdl/flash_pkg.sv ====
// Types shared by the flash program and erase controller.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package flash_pkg;
  typedef enum logic [1:0] {S_IDLE, S_PROG, S_ERASE} op_state_type;
  // Frame as left behind by the serial side when chip select rises
  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [9:0] nbytes;
    logic aligned;
  } frame_type;
endpackage
`default_nettype wire

// ==== hdl/flash_program_erase_control.sv ====
// Program, erase and write-enable control of a serial flash array.
// Assumes a host on the serial lines and core-side config levels.
//
// Contract
// R1: Opcode 02h programs up to 256 bytes into one page.
// R2: Program into a block-protected page is ignored, array untouched.
// R3: Program needs the write enable latch set beforehand.
// R4: Host sends opcode, three address bytes, 1 to 256 data bytes.
// R5: Program starts only when chip select rises after a valid sequence.
// R6: Work-in-progress bit is 1 during program or erase, else 0.
// R7: Over 256 data bytes wrap in page; last 256 are kept.
// R8: Start anywhere in page; after last byte continue at page start.
// R9: Bytes of the page that got no data stay unchanged.
// R10: Program only clears bits; only erase sets them to 1.
// R11: Opcode 32h/38h programs over four lines; needs quad enable and latch.
// R12: 4K sectors, 32K and 64K blocks; erase sets all bits.
// R13: Opcode D7h/20h erases a 4K sector; latch needed, cleared after.
// R14: Host keeps chip select low over opcode and address of erase.
// R15: Opcode 52h erases 32K, D8h erases 64K; latch needed and cleared.
// R16: Block erase takes opcode and address, starts at chip select rise.
// R17: Opcode C7h/60h erases all, no address; latch needed and cleared.
// R18: Whole erase only with protect field zero, else set both errors.
// R19: Opcode 06h sets the latch; latch clear after power-up.
// R20: Every array or nonvolatile write needs the latch.
// R21: Latch clears automatically when a gated write completes.
// R22: Opcode 04h clears the latch; the code ignores it while busy.
// R23: Four-line mode carries the opcode in two clocks.
// R24: Opcode 05h returns status including work-in-progress bit.
// R25: Bits sampled MSB first on rising serial clock, chip select low.
// R26: While busy, program, erase and write enable are ignored.
`include "flash_params.svh"
`default_nettype none
module flash_program_erase_control
  import flash_pkg::*;
(
  // Core clock, reset, enable
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // Serial link
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o,
  // Configuration
  input wire logic quad_enable_bit_i,
  input wire logic [3:0] block_protect_field_i,
  input wire logic four_line_peripheral_mode_i,
  input wire logic err_clear_i,
  // Status
  output logic work_in_progress_bit_o,
  output logic write_enable_latch_o,
  output logic erase_error_flag_o,
  output logic protection_error_flag_o,
  // Array inspection
  input wire logic [20:0] array_rd_addr_i,
  output logic [7:0] array_rd_data_o
);

  // ***********************************************************
  // Helpers
  // ***********************************************************
  function automatic logic is_prog(input logic [7:0] op);
    return (op == `OP_PROG) || (op == `OP_PROG_Q1) || (op == `OP_PROG_Q2);
  endfunction

  function automatic logic is_quad_prog(input logic [7:0] op);
    return (op == `OP_PROG_Q1) || (op == `OP_PROG_Q2);
  endfunction

  function automatic logic is_cer(input logic [7:0] op);
    return (op == `OP_CER_A) || (op == `OP_CER_B);
  endfunction

  function automatic logic [20:0] erase_mask(input logic [7:0] op);
    logic [20:0] m;
    m = '0;
    case (op)
      `OP_SER_A, `OP_SER_B: m = `SECT_MASK;
      `OP_BER32: m = `BLK32_MASK;
      `OP_BER64: m = `BLK64_MASK;
      `OP_CER_A, `OP_CER_B: m = `ARRAY_ALL;
      default: m = '0;
    endcase
    return m;
  endfunction

  // Top 2^(bp-1) 64K blocks are protected; six or more covers all
  function automatic logic prot_hit(input logic [3:0] bp, input logic [20:0] a);
    logic [5:0] first;
    first = '0;
    if (bp == 4'h0)
      return 1'b0;
    if (bp >= 4'h6)
      return 1'b1;
    first = `BLK64_COUNT - (6'h01 << (bp - 4'h1));
    return {1'b0, a[20:16]} >= first;
  endfunction

  // ***********************************************************
  // Link domain: shift in frames
  // ***********************************************************
  logic link_rst_n;
  logic [8:0] link_cfg;
  logic [7:0] stat_l;
  logic qpi_l;
  logic in_frame;
  logic frame_tog;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic [9:0] nbytes;
  logic [7:0] opcode;
  logic [23:0] addr;
  logic [7:0] col;
  logic [255:0] mask;
  logic [7:0] page_buf [0:255];
  logic [2:0] cur_bits;
  logic [9:0] cur_n;
  logic wide;
  logic [7:0] next_sh;
  logic byte_done;
  logic capture;
  logic status_read_cmd_act;
  logic [7:0] stat_core;
  frame_type link_frame;

  // Chip select high idles the link side with no clock running
  assign link_rst_n = arst_n_i & ~cs_n_i;

  sync2 #(.WIDTH(9)) u_link_sync (
    .clk_i(sclk_i),
    .arst_n_i(arst_n_i),
    .en_i(1'b1),
    .d_i({four_line_peripheral_mode_i, stat_core}),
    .q_o(link_cfg)
  );
  assign qpi_l = link_cfg[8];
  assign stat_l = link_cfg[7:0];

  assign cur_bits = in_frame ? bit_cnt : 3'h0;
  assign cur_n = in_frame ? nbytes : 10'h000;
  assign wide = qpi_l | (cur_n != 10'h000 && is_quad_prog(opcode)); // R11 R23
  assign next_sh = wide ? {shreg[3:0], io_i} : {shreg[6:0], io_i[0]}; // R25
  assign byte_done = wide ? cur_bits[2] : (cur_bits == 3'h7);
  // Page data is ignored while busy so a poll cannot corrupt it
  assign capture = byte_done && cur_n >= `HDR_BYTES && is_prog(opcode)
                   && !stat_l[`ST_WIP]; // R26
  assign status_read_cmd_act = in_frame && nbytes != 10'h000 && opcode == `OP_STATUS_READ_CMD;

  always_ff @(posedge sclk_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
      in_frame <= 1'b0;
    else
      in_frame <= 1'b1;
  end

  // One toggle per frame tells the core a new frame exists
  always_ff @(posedge sclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      frame_tog <= 1'b0;
    else if (!in_frame)
      frame_tog <= ~frame_tog;
  end

  always_ff @(posedge sclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      shreg <= '0;
      bit_cnt <= '0;
      nbytes <= '0;
    end
    else
    begin
      shreg <= next_sh;
      bit_cnt <= cur_bits + (wide ? 3'h4 : 3'h1);
      if (byte_done && cur_n != `NBYTES_SAT)
        nbytes <= cur_n + 10'h001;
      else
        nbytes <= cur_n;
    end
  end

  always_ff @(posedge sclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      opcode <= '0;
      addr <= '0;
      col <= '0;
    end
    else if (byte_done)
    begin
      if (cur_n == 10'h000)
        opcode <= next_sh; // R25
      else if (cur_n < `HDR_BYTES)
        addr <= {addr[15:0], next_sh};
      if (cur_n == `HDR_BYTES - 10'h001)
        col <= next_sh; // R8
      else if (capture)
        col <= col + 8'h01; // R7 R8
    end
  end

  always_ff @(posedge sclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      mask <= '0;
    // Only a program frame taken while idle clears it; a poll mid-program keeps the page
    else if (byte_done && cur_n == `HDR_BYTES - 10'h001 && is_prog(opcode)
             && !stat_l[`ST_WIP])
      mask <= '0; // R9 R26
    else if (capture)
      mask[col] <= 1'b1; // R9
  end

  // Later bytes overwrite earlier ones at the same column
  always_ff @(posedge sclk_i)
  begin
    if (capture)
      page_buf[col] <= next_sh; // R7
  end

  // Status shifts out on falling edges, repeating every byte
  always_ff @(negedge sclk_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      io_o <= '0;
      io_oe_o <= '0;
    end
    else if (status_read_cmd_act && qpi_l)
    begin
      io_o <= bit_cnt[2] ? stat_l[3:0] : stat_l[7:4]; // R24
      io_oe_o <= 4'hF;
    end
    else if (status_read_cmd_act)
    begin
      io_o <= {2'b00, stat_l[3'h7 - bit_cnt], 1'b0}; // R24
      io_oe_o <= 4'h2;
    end
    else
    begin
      io_o <= '0;
      io_oe_o <= '0;
    end
  end

  assign link_frame = '{opcode, addr, nbytes, bit_cnt == 3'h0};

  // ***********************************************************
  // Core domain: decode at frame end
  // ***********************************************************
  logic [1:0] core_s;
  logic cs_q;
  logic tog_seen;
  logic frame_end;
  logic go_prog;
  logic go_erase;
  logic cer_fail;
  logic op_done;
  logic len1;
  logic len4;
  logic lenp;
  logic [20:0] fa;
  logic [20:0] em;
  op_state_type state;
  logic [20:0] ptr;
  logic [20:0] last;
  logic [7:0] mem [0:(1 << `ARRAY_AW) - 1];

  sync2 #(.WIDTH(2)) u_core_sync (
    .clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .en_i(ce_i),
    .d_i({frame_tog, cs_n_i}),
    .q_o(core_s)
  );

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cs_q <= 1'b1;
      tog_seen <= 1'b0;
    end
    else if (ce_i)
    begin
      cs_q <= core_s[0];
      if (core_s[0] && !cs_q)
        tog_seen <= core_s[1];
    end
  end

  // Link registers are quiet here: chip select is high, clock stopped
  assign frame_end = ce_i && core_s[0] && !cs_q && core_s[1] != tog_seen; // R5
  assign fa = link_frame.addr[20:0];
  assign em = erase_mask(link_frame.opcode);
  assign len1 = link_frame.aligned && link_frame.nbytes == 10'h001;
  assign len4 = link_frame.aligned && link_frame.nbytes == `HDR_BYTES; // R14 R16
  assign lenp = link_frame.aligned && link_frame.nbytes > `HDR_BYTES; // R4
  assign go_prog = frame_end && !work_in_progress_bit_o && write_enable_latch_o
                   && lenp && is_prog(link_frame.opcode) // R1 R3 R20
                   && (quad_enable_bit_i || !is_quad_prog(link_frame.opcode)) // R11
                   && !prot_hit(block_protect_field_i, fa); // R2
  assign go_erase = frame_end && !work_in_progress_bit_o && write_enable_latch_o
                    && ((len4 && em != '0 && !is_cer(link_frame.opcode) // R13 R15
                         && !prot_hit(block_protect_field_i, fa & ~em))
                        || (len1 && is_cer(link_frame.opcode)
                            && block_protect_field_i == 4'h0)); // R17 R18
  assign cer_fail = frame_end && !work_in_progress_bit_o && write_enable_latch_o
                    && len1 && is_cer(link_frame.opcode)
                    && block_protect_field_i != 4'h0; // R18
  assign op_done = ce_i && state != S_IDLE && ptr == last;

  // ***********************************************************
  // Operation sequencer, one array byte per cycle
  // ***********************************************************
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state <= S_IDLE;
      work_in_progress_bit_o <= 1'b0;
      ptr <= '0;
      last <= '0;
    end
    else if (ce_i)
    begin
      case (state)
        S_IDLE:
        begin
          if (go_prog)
          begin
            state <= S_PROG;
            work_in_progress_bit_o <= 1'b1; // R6
            ptr <= {fa[20:8], 8'h00};
            last <= {fa[20:8], `PAGE_LAST};
          end
          else if (go_erase)
          begin
            state <= S_ERASE;
            work_in_progress_bit_o <= 1'b1; // R6
            ptr <= fa & ~em; // R12
            last <= fa | em;
          end
        end
        S_PROG, S_ERASE:
        begin
          if (ptr == last)
          begin
            state <= S_IDLE;
            work_in_progress_bit_o <= 1'b0; // R6
          end
          else
            ptr <= ptr + 21'h0_0001;
        end
        default:
        begin
          state <= S_IDLE;
          work_in_progress_bit_o <= 1'b0;
        end
      endcase
    end
  end

  // Array has no reset; it holds whatever it last stored
  always_ff @(posedge core_clk_i)
  begin
    if (ce_i)
    begin
      if (state == S_PROG && mask[ptr[7:0]])
        mem[ptr] <= mem[ptr] & page_buf[ptr[7:0]]; // R9 R10
      else if (state == S_ERASE)
        mem[ptr] <= 8'hFF; // R12
      array_rd_data_o <= mem[array_rd_addr_i];
    end
  end

  // ***********************************************************
  // Write enable latch and error flags
  // ***********************************************************
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      write_enable_latch_o <= 1'b0; // R19
    else if (ce_i)
    begin
      if (op_done)
        write_enable_latch_o <= 1'b0; // R21
      else if (frame_end && !work_in_progress_bit_o && len1) // R26
      begin
        if (link_frame.opcode == `OP_WRITE_ENABLE_CMD)
          write_enable_latch_o <= 1'b1; // R19
        else if (link_frame.opcode == `OP_WRITE_DISABLE_CMD)
          write_enable_latch_o <= 1'b0; // R22
      end
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      erase_error_flag_o <= 1'b0;
      protection_error_flag_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (cer_fail)
      begin
        erase_error_flag_o <= 1'b1; // R18
        protection_error_flag_o <= 1'b1;
      end
      else if (err_clear_i)
      begin
        erase_error_flag_o <= 1'b0;
        protection_error_flag_o <= 1'b0;
      end
    end
  end

  assign stat_core = {1'b0, quad_enable_bit_i, block_protect_field_i,
                      write_enable_latch_o, work_in_progress_bit_o};

  // ***********************************************************
  // Checks
  // ***********************************************************
  chk_write_enable_cmd_sets: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R19
    frame_end && !work_in_progress_bit_o && len1 && link_frame.opcode == `OP_WRITE_ENABLE_CMD
    |=> write_enable_latch_o)
    else $error("write enable did not set latch");

  chk_write_disable_cmd_clears: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R22
    frame_end && !work_in_progress_bit_o && len1 && link_frame.opcode == `OP_WRITE_DISABLE_CMD
    |=> !write_enable_latch_o)
    else $error("write disable left latch set");

  chk_busy_ignore: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R26
    frame_end && work_in_progress_bit_o && !op_done
    |=> work_in_progress_bit_o && $stable(last))
    else $error("command accepted while busy");

  chk_no_latch_idle: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R3
    frame_end && !work_in_progress_bit_o && !write_enable_latch_o
    |=> !work_in_progress_bit_o)
    else $error("write started without latch");

  chk_done_latch: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R21
    op_done |=> !write_enable_latch_o && !work_in_progress_bit_o)
    else $error("latch or busy left set after completion");

  chk_cer_protect: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R18
    cer_fail |=> erase_error_flag_o && protection_error_flag_o
    && !work_in_progress_bit_o)
    else $error("protected whole erase not refused");

  chk_prog_page: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R1
    $rose(state == S_PROG) |-> ptr[7:0] == 8'h00 && last[7:0] == 8'hFF
    && ptr[20:8] == last[20:8])
    else $error("program not bounded to one page");

  chk_erase_fill: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R12
    state == S_ERASE && ce_i |=> mem[$past(ptr)] == 8'hFF)
    else $error("erased byte not all ones");

  chk_prog_clear: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // R10
    state == S_PROG && ce_i
    |=> (mem[$past(ptr)] & ~$past(mem[ptr])) == 8'h00)
    else $error("program set a bit");
endmodule
`default_nettype wire

// ==== hdl/sync2.sv ====
// Two-flop level synchroniser, vector wide.
// Assumes each bit is a slowly changing level or a toggle.
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic en_i,
  // Data
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta <= '0;
      q_o <= '0;
    end
    else if (en_i)
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/flash_host_model.sv ====
// Behavioural host controller driving the serial flash lines.
// Assumes the bench merges these lines with the device's enables.
`include "flash_params.svh"
`default_nettype none
module flash_host_model
(
  // Serial lines
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] io_o,
  // Merged data lines
  input wire logic [3:0] io_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    io_o = 4'h0;
  end

  // Clock stands low outside frames
  task automatic pulse(input logic [3:0] v);
    io_o = v;
    #16 sclk_o = 1'b1;
    #16 sclk_o = 1'b0;
  endtask

  // Gap first, so the caller sees the device right from chip select rise
  task automatic send(input logic [7:0] b[$], input bit q_op, input bit q_rest,
                      input int extra);
    #200 cs_n_o = 1'b0;
    for (int i = 0; i < b.size(); i++)
    begin
      if ((i == 0) ? q_op : q_rest)
      begin
        pulse(b[i][7:4]);
        pulse(b[i][3:0]);
      end
      else
        for (int k = 7; k >= 0; k--)
          pulse({io_o[3:1], b[i][k]});
    end
    for (int k = 0; k < extra; k++)
      pulse({io_o[3:1], 1'b1});
    #16 cs_n_o = 1'b1;
    // Released lines must not keep the last value
    io_o = ~io_o;
  endtask

  // Mode level crosses on the serial clock, so a throwaway frame carries it
  task automatic prime();
    #200 cs_n_o = 1'b0;
    pulse(4'h0);
    pulse(4'h0);
    #16 cs_n_o = 1'b1;
  endtask

  task automatic status(output logic [7:0] s);
    logic [7:0] op;
    op = `OP_STATUS_READ_CMD;
    s = 8'h00;
    #200 cs_n_o = 1'b0;
    for (int k = 7; k >= 0; k--)
      pulse({io_o[3:1], op[k]});
    io_o = ~io_o;
    for (int k = 0; k < 8; k++)
    begin
      #16 sclk_o = 1'b1;
      s = {s[6:0], io_i[1]};
      #16 sclk_o = 1'b0;
    end
    #16 cs_n_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the flash program and erase controller.
// Assumes flash_host_model on the serial side and the hdl/ sources.
`include "flash_params.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic quad_en = 1'b0;
  logic four_line = 1'b0;
  logic err_clear = 1'b0;
  logic [3:0] bp = 4'h0;
  logic [20:0] rd_addr = 21'h0_0000;
  logic sclk, cs_n, work_in_progress_bit, write_enable_latch, e_err, p_err;
  logic [3:0] host_io, dut_io, dut_oe, io_wire;
  logic [7:0] rd_data, st;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;

  assign io_wire = (dut_oe & dut_io) | (~dut_oe & host_io);
  always #12.5 core_clk = ~core_clk;

  flash_host_model u_host (.sclk_o(sclk), .cs_n_o(cs_n), .io_o(host_io), .io_i(io_wire));

  flash_program_erase_control u_dut (
    .core_clk_i(core_clk), .arst_n_i(arst_n), .ce_i(1'b1), .sclk_i(sclk), .cs_n_i(cs_n),
    .io_i(io_wire), .io_o(dut_io), .io_oe_o(dut_oe), .quad_enable_bit_i(quad_en),
    .block_protect_field_i(bp), .four_line_peripheral_mode_i(four_line),
    .err_clear_i(err_clear), .work_in_progress_bit_o(work_in_progress_bit), .write_enable_latch_o(write_enable_latch),
    .erase_error_flag_o(e_err), .protection_error_flag_o(p_err),
    .array_rd_addr_i(rd_addr), .array_rd_data_o(rd_data));

  // ****************
  // Tasks
  // ****************
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp1(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmpn(input string what, input int exp, input int got);
    checked++;
    if (got != exp)
    begin
      err_count++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // Bit 7 flipped past 256 so wrapped bytes differ from early ones
  function automatic logic [7:0] pat(input logic [7:0] base, input int k);
    return base ^ 8'(k) ^ ((k > 255) ? 8'h80 : 8'h00);
  endfunction

  task automatic xfer(input logic [7:0] op, input int nadr, input logic [23:0] a,
                      input int n, input logic [7:0] base, input bit q_op = 1'b0,
                      input bit q_rest = 1'b0, input int extra = 0);
    logic [7:0] q[$];
    q = {op};
    for (int i = 2; i >= 3 - nadr; i--)
      q.push_back(a[8*i +: 8]);
    for (int k = 0; k < n; k++)
      q.push_back(pat(base, k));
    u_host.send(q, q_op, q_rest, extra);
  endtask

  task automatic cmd(input logic [7:0] op, input bit q = 1'b0);
    xfer(op, 0, 24'h00_0000, 0, 8'h00, q, q);
  endtask

  task automatic erase(input logic [7:0] op, input logic [23:0] a);
    xfer(op, 3, a, 0, 8'h00);
  endtask

  task automatic idle();
    repeat (10) @(negedge core_clk);
    cmp1("busy", 1'b0, work_in_progress_bit);
  endtask

  task automatic latch(input logic exp);
    repeat (10) @(negedge core_clk);
    cmp1("write enable latch", exp, write_enable_latch);
  endtask

  // Counts whole core cycles with the busy bit high
  task automatic busy(input int exp);
    int n;
    n = 0;
    for (int i = 0; i < 20 && work_in_progress_bit !== 1'b1; i++)
      @(negedge core_clk);
    while (work_in_progress_bit === 1'b1 && n < 70000)
    begin
      n++;
      @(negedge core_clk);
    end
    if (exp > 0)
      cmpn("busy cycles", exp, n);
    else
      cmpn("busy seen", 1, int'(n > 0));
  endtask

  task automatic mem(input logic [20:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    rd_addr = a;
    @(negedge core_clk);
    cmp8("array byte", exp, rd_data);
  endtask

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      err_count++;
      close_out();
    end
  end

  // ****************
  // Sequence
  // ****************
  initial
  begin
    repeat (4) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    cmp1("busy", 1'b0, work_in_progress_bit);
    latch(1'b0);
    erase(`OP_SER_A, 24'h00_0000);
    idle();
    cmd(`OP_WRITE_ENABLE_CMD);
    latch(1'b1);
    erase(`OP_SER_A, 24'h00_0000);
    busy(4096);
    latch(1'b0);
    mem(21'h0_0000, 8'hFF);
    mem(21'h0_0FFF, 8'hFF);
    xfer(`OP_PROG, 3, 24'h00_00F0, 20, 8'h3C);
    idle();
    mem(21'h0_00F0, 8'hFF);
    cmd(`OP_WRITE_ENABLE_CMD);
    xfer(`OP_PROG, 3, 24'h00_00F0, 20, 8'h3C);
    busy(256);
    mem(21'h0_00F0, pat(8'h3C, 0));
    mem(21'h0_00FF, pat(8'h3C, 15));
    mem(21'h0_0000, pat(8'h3C, 16));
    mem(21'h0_0003, pat(8'h3C, 19));
    mem(21'h0_0004, 8'hFF);
    mem(21'h0_00EF, 8'hFF);
    cmd(`OP_WRITE_ENABLE_CMD);
    xfer(`OP_PROG, 3, 24'h00_00F0, 1, 8'hF0);
    busy(256);
    mem(21'h0_00F0, 8'h30);
    cmd(`OP_WRITE_ENABLE_CMD);
    xfer(`OP_PROG, 3, 24'h00_00F1, 1, 8'h5A);
    u_host.status(st);
    cmp8("status in program", 8'h03, st);
    busy(0);
    mem(21'h0_00F1, 8'h18);
    cmd(`OP_WRITE_ENABLE_CMD);
    xfer(`OP_PROG, 3, 24'h00_0100, 258, 8'h11);
    busy(256);
    mem(21'h0_0100, pat(8'h11, 256));
    mem(21'h0_0101, pat(8'h11, 257));
    mem(21'h0_0102, pat(8'h11, 2));
    cmd(`OP_WRITE_ENABLE_CMD);
    xfer(`OP_PROG_Q1, 3, 24'h00_0200, 3, 8'h77, 1'b0, 1'b1);
    idle();
    quad_en = 1'b1;
    xfer(`OP_PROG_Q2, 3, 24'h00_0200, 3, 8'h77, 1'b0, 1'b1);
    busy(256);
    mem(21'h0_0202, pat(8'h77, 2));
    four_line = 1'b1;
    u_host.prime();
    cmd(`OP_WRITE_ENABLE_CMD, 1'b1);
    latch(1'b1);
    xfer(`OP_PROG, 3, 24'h00_0300, 4, 8'hC3, 1'b1, 1'b1);
    busy(256);
    mem(21'h0_0303, pat(8'hC3, 3));
    four_line = 1'b0;
    u_host.prime();
    cmd(`OP_WRITE_ENABLE_CMD);
    xfer(`OP_PROG, 3, 24'h00_0400, 2, 8'h99, 1'b0, 1'b0, 3);
    idle();
    mem(21'h0_0400, 8'hFF);
    erase(`OP_SER_B, 24'h00_1000);
    cmd(`OP_WRITE_DISABLE_CMD);
    u_host.status(st);
    cmp8("status while busy", 8'h43, st);
    busy(0);
    latch(1'b0);
    u_host.status(st);
    cmp8("status when idle", 8'h40, st);
    cmd(`OP_WRITE_ENABLE_CMD);
    erase(`OP_BER32, 24'h00_8000);
    busy(32768);
    mem(21'h0_8000, 8'hFF);
    mem(21'h0_FFFF, 8'hFF);
    mem(21'h0_00F0, 8'h30);
    bp = 4'h1;
    cmd(`OP_WRITE_ENABLE_CMD);
    xfer(`OP_PROG, 3, 24'h1F_0000, 1, 8'h00);
    idle();
    erase(`OP_BER64, 24'h1F_0000);
    idle();
    cmd(`OP_CER_A);
    idle();
    cmp1("erase error", 1'b1, e_err);
    cmp1("protection error", 1'b1, p_err);
    err_clear = 1'b1;
    @(negedge core_clk);
    err_clear = 1'b0;
    @(negedge core_clk);
    cmp1("error clear", 1'b0, e_err | p_err);
    cmd(`OP_CER_B);
    idle();
    cmp1("protection error", 1'b1, p_err);
    latch(1'b1);
    cmd(`OP_WRITE_DISABLE_CMD);
    latch(1'b0);
    close_out();
  end
endmodule
`default_nettype wire
